// ### core/servo_io_pkg.sv
// constants, field layouts and carrier types of the servo i/o function block
// What this block does
// - gain switching picks gain set one or two
// - digit 0001: closed set one, open set two
// - digit 0002: closed set two, open set one
// - default 0003 ignores input, always set one
// - gain digit is lowest config digit
// - mode switching picks control mode one or two
// - mode digit is third config digit
// - default ignores input; enabled settings map or invert
// - any fault warning disables drive; digit 1 asserts output
// - eleven listed warnings form the fault class
// - digit 1: output closed while warning present
// - digit 2: output closed while no warning
// - default 3: fault output off, pin general purpose
package servo_io_pkg;

  // ****************************************************
  // register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] OFS_IN_CFG   = 8'h00;
  localparam logic [7:0] OFS_OUT_CFG  = 8'h04;
  localparam logic [7:0] OFS_GAIN_ONE = 8'h08;
  localparam logic [7:0] OFS_GAIN_TWO = 8'h0C;
  localparam logic [7:0] OFS_MODE_ONE = 8'h10;
  localparam logic [7:0] OFS_MODE_TWO = 8'h14;
  localparam logic [7:0] OFS_GPO      = 8'h18;
  localparam logic [7:0] OFS_STATE    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;

  // ****************************************************
  // field positions and digit codes
  // ****************************************************
  localparam int GAIN_DIGIT_LSB  = 0;
  localparam int MODE_DIGIT_LSB  = 8;
  localparam int FAULT_DIGIT_LSB = 8;
  localparam int WARN_COUNT      = 11;
  localparam int IRQ_FAULT       = 0;
  localparam int IRQ_GAIN        = 1;
  localparam int IRQ_MODE        = 2;
  localparam logic [3:0] DIGIT_DIRECT   = 4'h1;
  localparam logic [3:0] DIGIT_INVERTED = 4'h2;
  localparam logic [3:0] DIGIT_DISABLED = 4'h3;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [15:0] RST_IN_CFG  = 16'h0303;
  localparam logic [15:0] RST_OUT_CFG = 16'h0300;
  localparam logic [15:0] RST_PARAM   = 16'h0000;
  localparam logic [2:0]  RST_IRQ     = 3'h0;

  // ****************************************************
  // carrier types
  // ****************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic {
    SET_ONE = 1'b0,
    SET_TWO = 1'b1
  } set_sel_t;

endpackage

// ### core/servo_io_function_select.sv
// gain switch, control mode switch and fault output with wishbone registers
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module servo_io_function_select
  import servo_io_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire wb_req_t               wb_i,
  output wb_rsp_t                    wb_o,
  input  wire logic                  gain_select_input_i,
  input  wire logic                  mode_select_input_i,
  input  wire logic [WARN_COUNT-1:0] warnings_i,
  output logic [15:0]                active_gain_o,
  output logic [15:0]                active_mode_o,
  output logic                       gain_two_active_o,
  output logic                       mode_two_active_o,
  output logic                       fault_output_o,
  output logic                       drive_enable_o,
  output logic                       irq_o
);

  // ****************************************************
  // helper functions
  // ****************************************************

  // true when the second set is chosen for a digit and pin level
  function automatic logic pick_two(input logic [3:0] digit,
                                    input logic       closed);
    logic r;
    r = 1'b0;
    if (digit == DIGIT_DIRECT) begin
      r = ~closed;
    end else if (digit == DIGIT_INVERTED) begin
      r = closed;
    end
    return r;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  // ****************************************************
  // registers and internal state
  // ****************************************************
  logic [15:0] in_cfg_reg;
  logic [15:0] out_cfg_reg;
  logic [15:0] gain_one_reg;
  logic [15:0] gain_two_reg;
  logic [15:0] mode_one_reg;
  logic [15:0] mode_two_reg;
  logic        gpo_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_en_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [1:0]  gain_sync_reg;
  logic [1:0]  mode_sync_reg;
  set_sel_t    gain_sel_reg;
  set_sel_t    mode_sel_reg;
  logic        fault_reg;
  logic        pin_reg;
  logic        wr_take;
  logic        rd_take;
  logic [3:0]  gain_digit;
  logic [3:0]  mode_digit;
  logic [3:0]  fault_digit;
  logic        any_warning;
  set_sel_t    gain_sel_next;
  set_sel_t    mode_sel_next;
  logic        pin_next;
  logic [2:0]  irq_set;
  logic [31:0] rdat_next;

  // ****************************************************
  // wishbone slave
  // ****************************************************

  // a write lands on the edge where the master sees ack high
  assign wr_take = wb_i.cyc & wb_i.stb & wb_i.we & ack_reg;
  assign rd_take = wb_i.cyc & wb_i.stb & ~ack_reg;

  // one ack per request, dropped in the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= rd_take;
      rdat_reg <= rd_take ? rdat_next : 32'h0000_0000;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdat_next = 32'h0000_0000;
    case (wb_i.adr)
      OFS_IN_CFG:   rdat_next[15:0] = in_cfg_reg;
      OFS_OUT_CFG:  rdat_next[15:0] = out_cfg_reg;
      OFS_GAIN_ONE: rdat_next[15:0] = gain_one_reg;
      OFS_GAIN_TWO: rdat_next[15:0] = gain_two_reg;
      OFS_MODE_ONE: rdat_next[15:0] = mode_one_reg;
      OFS_MODE_TWO: rdat_next[15:0] = mode_two_reg;
      OFS_GPO:      rdat_next[0]    = gpo_reg;
      OFS_STATE: begin
        rdat_next[0]    = gain_sel_reg;
        rdat_next[1]    = mode_sel_reg;
        rdat_next[2]    = fault_reg;
        rdat_next[3]    = pin_reg;
        rdat_next[26:16] = warnings_i;
      end
      OFS_IRQ_STAT: rdat_next[2:0] = irq_stat_reg;
      OFS_IRQ_EN:   rdat_next[2:0] = irq_en_reg;
      default:      rdat_next = 32'h0000_0000;
    endcase
  end

  assign wb_o.ack = ack_reg;
  assign wb_o.dat = rdat_reg;

  // configuration and parameter registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_cfg_reg   <= RST_IN_CFG;
      out_cfg_reg  <= RST_OUT_CFG;
      gain_one_reg <= RST_PARAM;
      gain_two_reg <= RST_PARAM;
      mode_one_reg <= RST_PARAM;
      mode_two_reg <= RST_PARAM;
      gpo_reg      <= 1'b0;
      irq_en_reg   <= RST_IRQ;
    end else if (wr_take) begin
      case (wb_i.adr)
        OFS_IN_CFG:
          in_cfg_reg <= merge16(in_cfg_reg, wb_i.dat, wb_i.sel);
        OFS_OUT_CFG:
          out_cfg_reg <= merge16(out_cfg_reg, wb_i.dat, wb_i.sel);
        OFS_GAIN_ONE:
          gain_one_reg <= merge16(gain_one_reg, wb_i.dat, wb_i.sel);
        OFS_GAIN_TWO:
          gain_two_reg <= merge16(gain_two_reg, wb_i.dat, wb_i.sel);
        OFS_MODE_ONE:
          mode_one_reg <= merge16(mode_one_reg, wb_i.dat, wb_i.sel);
        OFS_MODE_TWO:
          mode_two_reg <= merge16(mode_two_reg, wb_i.dat, wb_i.sel);
        OFS_GPO: begin
          if (wb_i.sel[0]) begin
            gpo_reg <= wb_i.dat[0];
          end
        end
        OFS_IRQ_EN: begin
          if (wb_i.sel[0]) begin
            irq_en_reg <= wb_i.dat[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ****************************************************
  // input synchronisers
  // ****************************************************

  // two flops per pin, only stage two feeds the logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_sync_reg <= 2'b00;
      mode_sync_reg <= 2'b00;
    end else begin
      gain_sync_reg <= {gain_sync_reg[0], gain_select_input_i};
      mode_sync_reg <= {mode_sync_reg[0], mode_select_input_i};
    end
  end

  // ****************************************************
  // gain and mode selection
  // ****************************************************
  assign gain_digit  = in_cfg_reg[GAIN_DIGIT_LSB +: 4];
  assign mode_digit  = in_cfg_reg[MODE_DIGIT_LSB +: 4];
  assign fault_digit = out_cfg_reg[FAULT_DIGIT_LSB +: 4];

  // any digit other than 1 or 2 keeps set one
  assign gain_sel_next = set_sel_t'(pick_two(gain_digit,
                                             gain_sync_reg[1]));
  assign mode_sel_next = set_sel_t'(pick_two(mode_digit,
                                             mode_sync_reg[1]));

  // active gain set and control mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_sel_reg  <= SET_ONE;
      mode_sel_reg  <= SET_ONE;
      active_gain_o <= RST_PARAM;
      active_mode_o <= RST_PARAM;
    end else begin
      gain_sel_reg  <= gain_sel_next;
      mode_sel_reg  <= mode_sel_next;
      active_gain_o <= (gain_sel_next == SET_TWO) ?
                       gain_two_reg : gain_one_reg;
      active_mode_o <= (mode_sel_next == SET_TWO) ?
                       mode_two_reg : mode_one_reg;
    end
  end

  assign gain_two_active_o = gain_sel_reg;
  assign mode_two_active_o = mode_sel_reg;

  // ****************************************************
  // fault output
  // ****************************************************
  assign any_warning = |warnings_i;

  // pin level: 1 is closed
  always_comb begin
    case (fault_digit)
      DIGIT_DIRECT:   pin_next = any_warning;
      DIGIT_INVERTED: pin_next = ~any_warning;
      default:        pin_next = gpo_reg;
    endcase
  end

  // fault flag and pin change on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
      pin_reg   <= 1'b0;
    end else begin
      fault_reg <= any_warning;
      pin_reg   <= pin_next;
    end
  end

  assign fault_output_o = pin_reg;
  assign drive_enable_o = ~fault_reg;

  // ****************************************************
  // interrupts
  // ****************************************************
  assign irq_set[IRQ_FAULT] = any_warning & ~fault_reg;
  assign irq_set[IRQ_GAIN]  = gain_sel_next != gain_sel_reg;
  assign irq_set[IRQ_MODE]  = mode_sel_next != mode_sel_reg;

  // sticky status, a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= RST_IRQ;
    end else if (wr_take && wb_i.adr == OFS_IRQ_CLR && wb_i.sel[0]) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_i.dat[2:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_gain_direct_map: assert property (
    gain_digit == DIGIT_DIRECT |=>
      gain_two_active_o == !$past(gain_sync_reg[1]))
    else $error("gain set wrong for direct mapping");

  chk_gain_inverted_map: assert property (
    gain_digit == DIGIT_INVERTED |=>
      gain_two_active_o == $past(gain_sync_reg[1]))
    else $error("gain set wrong for inverted mapping");

  chk_gain_default_one: assert property (
    gain_digit == DIGIT_DISABLED |=> !gain_two_active_o)
    else $error("gain set two used while disabled");

  chk_gain_value_out: assert property (
    gain_two_active_o |-> active_gain_o == $past(gain_two_reg))
    else $error("active gain does not match gain set two");

  chk_gain_one_value: assert property (
    !gain_two_active_o |-> active_gain_o == $past(gain_one_reg))
    else $error("active gain does not match gain set one");

  chk_mode_inverted_map: assert property (
    mode_digit == DIGIT_INVERTED |=>
      mode_two_active_o == $past(mode_sync_reg[1]))
    else $error("control mode wrong for inverted mapping");

  chk_mode_value_out: assert property (
    mode_two_active_o |-> active_mode_o == $past(mode_two_reg))
    else $error("active mode does not match control mode two");

  chk_mode_default_one: assert property (
    mode_digit == DIGIT_DISABLED |=>
      !mode_two_active_o && active_mode_o == $past(mode_one_reg))
    else $error("control mode two used while disabled");

  chk_mode_direct_map: assert property (
    mode_digit == DIGIT_DIRECT && in_cfg_reg == $past(in_cfg_reg) |=>
      mode_two_active_o == !$past(mode_sync_reg[1]))
    else $error("control mode wrong for direct mapping");

  chk_fault_disable_drive: assert property (
    any_warning |=> !drive_enable_o)
    else $error("drive still enabled after a warning");

  chk_fault_event_kept: assert property (
    irq_set[IRQ_FAULT] |=> irq_stat_reg[IRQ_FAULT])
    else $error("fault event lost in status");

  chk_fault_closed_warn: assert property (
    fault_digit == DIGIT_DIRECT |=> fault_output_o == $past(any_warning))
    else $error("fault pin not closed on warning");

  chk_fault_closed_ok: assert property (
    fault_digit == DIGIT_INVERTED |=>
      fault_output_o == !$past(any_warning))
    else $error("fault pin not closed while healthy");

  chk_fault_pin_gpo: assert property (
    fault_digit == DIGIT_DISABLED |=> fault_output_o == $past(gpo_reg))
    else $error("fault pin not general purpose");

  chk_sync_two_stage: assert property (
    $rose(gain_select_input_i) ##1 gain_select_input_i |=>
      gain_sync_reg[1])
    else $error("gain input not through two stages");

  chk_mode_sync_stage: assert property (
    $fell(mode_select_input_i) ##1 !mode_select_input_i |=>
      !mode_sync_reg[1])
    else $error("mode input not through two stages");

endmodule

// ### verif/servo_io_switch_model.sv
// external switches and warning sources facing the servo i/o block
`timescale 1ns/1ps
module servo_io_switch_model
  import servo_io_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  gain_closed_i,
  input  wire logic                  mode_closed_i,
  input  wire logic [WARN_COUNT-1:0] warn_i,
  output logic                       gain_select_input_o,
  output logic                       mode_select_input_o,
  output logic [WARN_COUNT-1:0]      warnings_o
);
  // contacts move just after an edge, never against it; the block is
  // held in reset over the first edges, so the start level is covered
  always @(posedge clk_i) begin
    gain_select_input_o <= gain_closed_i;
    mode_select_input_o <= mode_closed_i;
    warnings_o          <= warn_i;
  end
endmodule

// ### verif/servo_io_function_select_tb_top.sv
// self-checking bench for the servo i/o function block
`timescale 1ns/1ps
module servo_io_function_select_tb_top
  import servo_io_pkg::*;
;
  logic                  clk_i, rst_i, gain_cmd, mode_cmd;
  logic [WARN_COUNT-1:0] warn_cmd, warn_pin;
  wire logic             gain_pin, mode_pin;
  wb_req_t               wb_req;
  wb_rsp_t               wb_rsp;
  logic [15:0]           act_gain, act_mode;
  logic                  gain_two, mode_two, fault_pin, drive_en, irq;
  int                    miscompares, n_compared, cycles;
  logic [31:0]           rd;

  servo_io_switch_model servo_io_switch_model_inst (
    .clk_i(clk_i), .gain_closed_i(gain_cmd), .mode_closed_i(mode_cmd),
    .warn_i(warn_cmd), .gain_select_input_o(gain_pin),
    .mode_select_input_o(mode_pin), .warnings_o(warn_pin));

  servo_io_function_select servo_io_function_select_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
    .gain_select_input_i(gain_pin), .mode_select_input_i(mode_pin),
    .warnings_i(warn_pin), .active_gain_o(act_gain),
    .active_mode_o(act_mode), .gain_two_active_o(gain_two),
    .mode_two_active_o(mode_two), .fault_output_o(fault_pin),
    .drive_enable_o(drive_en), .irq_o(irq));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; holds everything until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
    check(n, 2, "ack latency");
  endtask

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask

  task automatic wb_rd(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0000_0000, q);
  endtask

  // selection of the second set for a digit and a contact level
  function automatic logic sel_two(input logic [3:0] dg, input logic cl);
    return (dg == DIGIT_DIRECT) ? !cl : (dg == DIGIT_INVERTED) ? cl : 1'b0;
  endfunction

  task automatic test_reset();
    check(drive_en, 1, "enable after reset");
    check(fault_pin, 0, "fault pin after reset");
    check(irq, 0, "irq after reset");
    wb_rd(OFS_IN_CFG, rd);
    check(rd, 32'h0000_0303, "input cfg reset");
    wb_rd(OFS_OUT_CFG, rd);
    check(rd, 32'h0000_0300, "output cfg reset");
    wb_wr(8'h3c, 32'h0000_ffff);
    wb_rd(8'h3c, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    wb_rd(OFS_IRQ_CLR, rd);
    check(rd, 32'h0000_0000, "clear reads zero");
    $display("test reset done");
  endtask

  // every digit code on both selects, with differing digits per field
  task automatic test_switch();
    logic [3:0] g, m;
    logic       gs, ms;
    wb_wr(OFS_GAIN_ONE, 32'h0000_1111);
    wb_wr(OFS_GAIN_TWO, 32'h0000_2222);
    wb_wr(OFS_MODE_ONE, 32'h0000_3333);
    wb_wr(OFS_MODE_TWO, 32'h0000_4444);
    for (int d = 1; d <= 3; d++) begin
      for (int p = 0; p <= 1; p++) begin
        g = 4'(d);
        m = 4'(d % 3 + 1);
        gs = sel_two(g, 1'(p));
        ms = sel_two(m, 1'(p));
        wb_wr(OFS_IN_CFG, {20'h0_0000, m, 4'h0, g});
        gain_cmd <= 1'(p);
        mode_cmd <= 1'(p);
        repeat (6) @(posedge clk_i);
        check(gain_two, gs, "gain set");
        check(act_gain, gs ? 16'h2222 : 16'h1111, "gain");
        check(mode_two, ms, "mode");
        check(act_mode, ms ? 16'h4444 : 16'h3333, "mode v");
      end
    end
    $display("test switch done");
  endtask

  // each warning alone under every fault pin setting, then healthy
  task automatic test_fault();
    logic any, want;
    wb_wr(OFS_GPO, 32'h0000_0001);
    for (int d = 1; d <= 3; d++) begin
      wb_wr(OFS_OUT_CFG, 32'(d) << 8);
      for (int i = 0; i <= WARN_COUNT; i++) begin
        warn_cmd <= (i == WARN_COUNT) ? '0 : WARN_COUNT'(1) << i;
        any = (i != WARN_COUNT);
        want = (d == 1) ? any : (d == 2) ? !any : 1'b1;
        repeat (3) @(posedge clk_i);
        check(fault_pin, want, "pin");
        if (d != 3) check(drive_en, !any, "drive enable");
      end
    end
    $display("test fault done");
  endtask

  // fault event masked, then enabled, then cleared
  task automatic test_irq();
    wb_wr(OFS_IRQ_EN, 32'h0000_0000);
    wb_wr(OFS_IRQ_CLR, 32'h0000_0007);
    warn_cmd <= WARN_COUNT'(8);
    repeat (3) @(posedge clk_i);
    check(irq, 0, "masked irq");
    wb_wr(OFS_IRQ_STAT, 32'h0000_0000);
    wb_rd(OFS_IRQ_STAT, rd);
    check(rd & 32'h0000_0001, 32'h0000_0001, "fault status");
    wb_wr(OFS_IRQ_EN, 32'h0000_0001);
    @(posedge clk_i);
    check(irq, 1, "enabled irq");
    warn_cmd <= '0;
    wb_wr(OFS_IRQ_CLR, 32'h0000_0001);
    wb_rd(OFS_IRQ_STAT, rd);
    check(rd & 32'h0000_0001, 32'h0000_0000, "status cleared");
    check(irq, 0, "irq cleared");
    // mode digit is direct here: opening the contact moves to mode two
    mode_cmd <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb_rd(OFS_IRQ_STAT, rd);
    check(rd, 32'h0000_0004, "mode change status");
    $display("test irq done");
  endtask

  initial begin
    rst_i    = 1'b1;
    wb_req   = '0;
    gain_cmd = 1'b0;
    mode_cmd = 1'b0;
    warn_cmd = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_reset();
    test_switch();
    test_fault();
    test_irq();
    finish_test();
  end
endmodule
